// file: pkg/iled_map.vh
`ifndef ILED_MAP_VH
`define ILED_MAP_VH

// Bus geometry
`define ILED_ADDR_W        8
`define ILED_DATA_W        32
`define ILED_LINES         32

// Register byte offsets, one aligned word each
`define ILED_OFF_EDGE_SEL  8'h00
`define ILED_OFF_LEVEL_SEL 8'h04
`define ILED_OFF_MODE_STAT 8'h08
`define ILED_OFF_FALL_SEL  8'h0C
`define ILED_OFF_RISE_SEL  8'h10
`define ILED_OFF_POL_STAT  8'h14
`define ILED_OFF_EVT_STAT  8'h18
`define ILED_OFF_EVT_MASK  8'h1C
`define ILED_OFF_EVT_CLR   8'h20
`define ILED_OFF_LINE_STAT 8'h24

// Alignment field of the byte address
`define ILED_ALIGN_MSB     1
`define ILED_ALIGN_LSB     0
`define ILED_ALIGN_OK      2'h0

// Reset values: edge mode, falling polarity, all masked
`define ILED_RST_MODE      32'h00000000
`define ILED_RST_POL       32'h00000000
`define ILED_RST_MASK      32'h00000000
`define ILED_RST_STAT      32'h00000000
`define ILED_RST_LINE      32'h00000000
`define ILED_RST_DATA      32'h00000000

// Bit meaning in the status views
`define ILED_MODE_EDGE     1'b0
`define ILED_MODE_LEVEL    1'b1
`define ILED_POL_FALL_LOW  1'b0
`define ILED_POL_RISE_HIGH 1'b1

// Sample qualification stages after reset
`define ILED_ARM_W         2
`define ILED_ARM_RST       2'h0
`define ILED_ARM_SAMPLE    0
`define ILED_ARM_PREV      1

`endif

// file: hw/iled_top.v
//
// Behaviour
// - Writing one to a line's bit in edge or level select picks its detection type.
// - Edge/level status register shows per line whether edge or level is chosen.
// - Falling/low and rising/high select writes set each line's detection polarity.
// - Polarity status register shows per line the current polarity choice.
// - A configured edge or level condition on a line sets its event status bit.
// - Interrupt asserts when a status bit and its mask bit are both set.
// - Masked events of all lines are ORed into one interrupt output.
// - Reading event status clears the bits it returns; software services them all.
// - Level events keep reasserting while the level persists, even after reads.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "iled_map.vh"

module iled_top #(
	parameter NUM_LINES = `ILED_LINES
) (
	// Clock and reset
	input  wire                     pclk,
	input  wire                     presetn,
	// APB slave
	input  wire [`ILED_ADDR_W-1:0]  paddr,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`ILED_DATA_W-1:0]  pwdata,
	output wire [`ILED_DATA_W-1:0]  prdata,
	output wire                     pready,
	output wire                     pslverr,
	// Input lines, synchronous to pclk
	input  wire [NUM_LINES-1:0]     line_in,
	// Combined interrupt
	output wire                     irq
);

	// Per-line configuration and state
	reg  [NUM_LINES-1:0]    mode_ff;
	reg  [NUM_LINES-1:0]    nxt_mode;
	reg  [NUM_LINES-1:0]    pol_ff;
	reg  [NUM_LINES-1:0]    nxt_pol;
	reg  [NUM_LINES-1:0]    mask_ff;
	reg  [NUM_LINES-1:0]    nxt_mask;
	reg  [NUM_LINES-1:0]    status_ff;
	reg  [NUM_LINES-1:0]    nxt_status;
	reg  [NUM_LINES-1:0]    sample_ff;
	reg  [NUM_LINES-1:0]    prev_ff;
	reg  [`ILED_ARM_W-1:0]  arm_ff;
	reg  [`ILED_DATA_W-1:0] prdata_ff;
	reg  [`ILED_DATA_W-1:0] nxt_prdata;
	reg                     irq_ff;

	// Bus phase decode
	wire                    setup_ph;
	wire                    access_ph;
	wire                    wr_acc;
	wire                    rd_acc;
	wire                    aligned;

	// Address hits
	wire                    hit_edge_sel;
	wire                    hit_level_sel;
	wire                    hit_mode_stat;
	wire                    hit_fall_sel;
	wire                    hit_rise_sel;
	wire                    hit_pol_stat;
	wire                    hit_evt_stat;
	wire                    hit_evt_mask;
	wire                    hit_evt_clr;
	wire                    hit_line_stat;
	wire                    hit_any;
	wire                    hit_ro;

	// Event and clear vectors
	wire [NUM_LINES-1:0]    evt;
	wire [NUM_LINES-1:0]    wdat;
	wire [NUM_LINES-1:0]    rd_clr;
	wire [NUM_LINES-1:0]    wr_clr;
	wire                    sample_ok;
	wire                    prev_ok;

	// APB phases; pready high in every access phase so every access ends in one cycle
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_acc    = access_ph & pwrite;
	assign rd_acc    = access_ph & ~pwrite;
	assign aligned   = (paddr[`ILED_ALIGN_MSB:`ILED_ALIGN_LSB] == `ILED_ALIGN_OK);

	// Register address decode
	assign hit_edge_sel  = aligned & (paddr == `ILED_OFF_EDGE_SEL);
	assign hit_level_sel = aligned & (paddr == `ILED_OFF_LEVEL_SEL);
	assign hit_mode_stat = aligned & (paddr == `ILED_OFF_MODE_STAT);
	assign hit_fall_sel  = aligned & (paddr == `ILED_OFF_FALL_SEL);
	assign hit_rise_sel  = aligned & (paddr == `ILED_OFF_RISE_SEL);
	assign hit_pol_stat  = aligned & (paddr == `ILED_OFF_POL_STAT);
	assign hit_evt_stat  = aligned & (paddr == `ILED_OFF_EVT_STAT);
	assign hit_evt_mask  = aligned & (paddr == `ILED_OFF_EVT_MASK);
	assign hit_evt_clr   = aligned & (paddr == `ILED_OFF_EVT_CLR);
	assign hit_line_stat = aligned & (paddr == `ILED_OFF_LINE_STAT);

	// Read-only views refuse writes
	assign hit_ro  = hit_mode_stat | hit_pol_stat | hit_evt_stat | hit_line_stat;
	assign hit_any = hit_edge_sel | hit_level_sel | hit_fall_sel | hit_rise_sel |
			 hit_evt_mask | hit_evt_clr | hit_ro;

	// Bus answer: zero wait states, error on unmapped or write to read-only
	assign pready  = access_ph;
	assign pslverr = access_ph & (~hit_any | (pwrite & hit_ro));
	assign prdata  = prdata_ff;
	assign irq     = irq_ff;

	// Write data narrowed to the line count
	assign wdat = pwdata[NUM_LINES-1:0];

	// Samples become trustworthy one and two clocks after reset release
	assign sample_ok = arm_ff[`ILED_ARM_SAMPLE];
	assign prev_ok   = arm_ff[`ILED_ARM_PREV];

	// Per-line detector
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
			wire rise;
			wire fall;
			wire edge_hit;
			wire level_hit;

			// Transition seen between consecutive samples
			assign rise = sample_ff[gi] & ~prev_ff[gi];
			assign fall = ~sample_ff[gi] & prev_ff[gi];

			// Polarity picks which transition or level counts
			assign edge_hit  = prev_ok & ((pol_ff[gi] == `ILED_POL_RISE_HIGH) ? rise : fall);
			assign level_hit = sample_ok &
					   ((pol_ff[gi] == `ILED_POL_RISE_HIGH) ? sample_ff[gi] :
					    ~sample_ff[gi]);

			// Level hit is raised every clock while the condition holds
			assign evt[gi] = (mode_ff[gi] == `ILED_MODE_LEVEL) ? level_hit : edge_hit;
		end
	endgenerate

	// Read clears only bits reported at setup, so a later event is not lost
	assign rd_clr = (rd_acc & hit_evt_stat) ? prdata_ff[NUM_LINES-1:0] :
			{NUM_LINES{1'b0}};
	assign wr_clr = (wr_acc & hit_evt_clr) ? wdat : {NUM_LINES{1'b0}};

	// Detection type: edge select clears, level select sets the mode bit
	always @* begin
		nxt_mode = mode_ff;
		if (wr_acc & hit_edge_sel) begin
			nxt_mode = mode_ff & ~wdat;
		end
		if (wr_acc & hit_level_sel) begin
			nxt_mode = mode_ff | wdat;
		end
	end

	// Polarity: falling/low clears, rising/high sets the polarity bit
	always @* begin
		nxt_pol = pol_ff;
		if (wr_acc & hit_fall_sel) begin
			nxt_pol = pol_ff & ~wdat;
		end
		if (wr_acc & hit_rise_sel) begin
			nxt_pol = pol_ff | wdat;
		end
	end

	// Mask is a plain read/write enable word
	always @* begin
		nxt_mask = mask_ff;
		if (wr_acc & hit_evt_mask) begin
			nxt_mask = wdat;
		end
	end

	// Sticky status; a fresh event wins over a clear in the same clock
	always @* begin
		nxt_status = (status_ff & ~(rd_clr | wr_clr)) | evt;
	end

	// Read mux, sampled in the setup phase
	always @* begin
		nxt_prdata = prdata_ff;
		if (setup_ph & ~pwrite) begin
			nxt_prdata = `ILED_RST_DATA;
			if (hit_mode_stat) begin
				nxt_prdata[NUM_LINES-1:0] = mode_ff;
			end
			if (hit_pol_stat) begin
				nxt_prdata[NUM_LINES-1:0] = pol_ff;
			end
			if (hit_evt_stat) begin
				nxt_prdata[NUM_LINES-1:0] = status_ff;
			end
			if (hit_evt_mask) begin
				nxt_prdata[NUM_LINES-1:0] = mask_ff;
			end
			if (hit_line_stat) begin
				nxt_prdata[NUM_LINES-1:0] = sample_ff;
			end
		end
	end

	// Configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= `ILED_RST_MODE;
			pol_ff  <= `ILED_RST_POL;
			mask_ff <= `ILED_RST_MASK;
		end else begin
			mode_ff <= nxt_mode;
			pol_ff  <= nxt_pol;
			mask_ff <= nxt_mask;
		end
	end

	// Input sampling; arm stages hide the reset value of the samples
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_ff <= `ILED_RST_LINE;
			prev_ff   <= `ILED_RST_LINE;
			arm_ff    <= `ILED_ARM_RST;
		end else begin
			sample_ff <= line_in;
			prev_ff   <= sample_ff;
			arm_ff    <= {arm_ff[`ILED_ARM_SAMPLE], 1'b1};
		end
	end

	// Event status and read data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= `ILED_RST_STAT;
			prdata_ff <= `ILED_RST_DATA;
		end else begin
			status_ff <= nxt_status;
			prdata_ff <= nxt_prdata;
		end
	end

	// Interrupt from next state so it moves with the status bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & nxt_mask);
		end
	end

endmodule // iled_top

`default_nettype wire

// file: testbench/iled_line_src.sv
`timescale 1ns/100ps
`default_nettype none
module iled_line_src #(parameter N = 32) (
	// Clock and wanted levels
	input  wire logic         pclk,
	input  wire logic [N-1:0] want,
	// Lines toward the block
	output var  logic [N-1:0] line_in
);
	// Lines move just after an edge, as a synchronous source would
	always @(posedge pclk) begin
		line_in <= want;
	end
endmodule // iled_line_src
`default_nettype wire

// file: testbench/iled_props.sv
`timescale 1ns/100ps
`default_nettype none
module iled_props #(parameter NUM_LINES = 32) (
	// Clock, reset, APB
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic [7:0]           paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Lines and interrupt
	input wire logic [NUM_LINES-1:0] line_in,
	input wire logic                 irq
);
	localparam int N = NUM_LINES;
	logic [N-1:0] mode_ff, pol_ff, msk_ff, prv_ff;
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	// Shadow of config, so checks need no view inside
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= '0;
			pol_ff <= '0;
			msk_ff <= '0;
			prv_ff <= '0;
		end else begin
			if (wr && paddr == 8'h00) mode_ff <= mode_ff & ~pwdata[N-1:0];
			if (wr && paddr == 8'h04) mode_ff <= mode_ff | pwdata[N-1:0];
			if (wr && paddr == 8'h0C) pol_ff <= pol_ff & ~pwdata[N-1:0];
			if (wr && paddr == 8'h10) pol_ff <= pol_ff | pwdata[N-1:0];
			if (wr && paddr == 8'h1C) msk_ff <= pwdata[N-1:0];
			prv_ff <= line_in;
		end
	end
	// Enabled events as the rules define them
	wire [N-1:0] rise = line_in & ~prv_ff & ~mode_ff & pol_ff & msk_ff;
	wire [N-1:0] fall = ~line_in & prv_ff & ~mode_ff & ~pol_ff & msk_ff;
	wire [N-1:0] lvl = mode_ff & msk_ff & ~(line_in ^ pol_ff);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mode; rd && paddr == 8'h08 |-> prdata[N-1:0] == mode_ff; endproperty
	a_mode: assert property (p_mode) else $error("mode view wrong");
	property p_pol; rd && paddr == 8'h14 |-> prdata[N-1:0] == pol_ff; endproperty
	a_pol: assert property (p_pol) else $error("polarity view wrong");
	property p_rise; |rise |-> ##2 irq; endproperty
	a_rise: assert property (p_rise) else $error("rise not flagged");
	property p_fall; |fall |-> ##2 irq; endproperty
	a_fall: assert property (p_fall) else $error("fall not flagged");
	property p_lvl; (|lvl)[*3] |-> irq; endproperty
	a_lvl: assert property (p_lvl) else $error("level not held");
	property p_or; irq |-> |msk_ff; endproperty
	a_or: assert property (p_or) else $error("irq without mask");
	// Two quiet clocks before the access: an edge seen at setup would survive the clear
	property p_clr; $stable(line_in) ##1 $stable(line_in) ##1 (rd && paddr == 8'h18 && mode_ff == '0
		&& $stable(line_in)) ##1 $stable(line_in) |=> !irq; endproperty
	a_clr: assert property (p_clr) else $error("read left irq");
	property p_quiet; $stable(line_in) ##1 (!irq && mode_ff == '0 && $stable(line_in))
		|=> (!irq || $changed(msk_ff)); endproperty
	a_quiet: assert property (p_quiet) else $error("event without edge");
endmodule // iled_props
bind iled_top iled_props #(.NUM_LINES(NUM_LINES)) u_props (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .line_in, .irq);
`default_nettype wire

// file: testbench/io_line_event_detector_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module io_line_event_detector_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, want, line_in, q;
	int failures, total_checks;
	iled_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .line_in, .irq);
	iled_line_src src (.pclk, .want, .line_in);
	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// One APB transfer; idle cycle first so psel is never set twice per step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) failures++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask
	task t_regs;
		rc("mode", 8'h08, 32'h0);
		rc("pol", 8'h14, 32'h0);
		apb(1'b1, 8'h04, 32'h0C);
		rc("mode", 8'h08, 32'h0C);
		chk("ok_err", 32'(err), 32'h0);
		rc("wo_read", 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h04);
		rc("mode", 8'h08, 32'h08);
		apb(1'b1, 8'h10, 32'h05);
		rc("pol", 8'h14, 32'h05);
		apb(1'b1, 8'h0C, 32'h01);
		rc("pol", 8'h14, 32'h04);
		apb(1'b1, 8'h08, 32'hFF);
		chk("ro_err", 32'(err), 32'h1);
		rc("mode", 8'h08, 32'h08);
		apb(1'b0, 8'h40, 32'h0);
		chk("map_err", 32'(err), 32'h1);
		apb(1'b1, 8'h00, 32'h08);
		// Misaligned write to level select must be refused and ignored
		apb(1'b1, 8'h05, 32'hFF);
		chk("mis_err", 32'(err), 32'h1);
		rc("mode", 8'h08, 32'h0);
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
	endtask
	task t_edge;
		apb(1'b1, 8'h1C, 32'h03);
		apb(1'b1, 8'h10, 32'h01);
		want <= 32'h2;
		cyc(5);
		chk("irq", 32'(irq), 32'h0);
		want <= 32'h3;
		cyc(5);
		chk("irq", 32'(irq), 32'h1);
		rc("line", 8'h24, 32'h3);
		rc("evt", 8'h18, 32'h1);
		rc("evt", 8'h18, 32'h0);
		chk("irq", 32'(irq), 32'h0);
		want <= 32'h1;
		cyc(5);
		rc("evt", 8'h18, 32'h2);
		// One-clock pulse on a masked-off line
		want <= 32'h5;
		@(posedge pclk);
		want <= 32'h1;
		cyc(5);
		chk("irq", 32'(irq), 32'h0);
		apb(1'b1, 8'h1C, 32'h04);
		cyc(2);
		chk("irq", 32'(irq), 32'h1);
		apb(1'b1, 8'h20, 32'h04);
		cyc(2);
		chk("irq", 32'(irq), 32'h0);
	endtask
	task t_lvl;
		apb(1'b1, 8'h1C, 32'h08);
		apb(1'b1, 8'h04, 32'h08);
		cyc(4);
		chk("irq", 32'(irq), 32'h1);
		rc("evt", 8'h18, 32'h8);
		rc("evt", 8'h18, 32'h8);
		want <= 32'h9;
		cyc(5);
		rc("evt", 8'h18, 32'h8);
		rc("evt", 8'h18, 32'h0);
		chk("irq", 32'(irq), 32'h0);
	endtask
	task final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Main sequence, reset held two cycles
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
		failures = 0;
		total_checks = 0;
		cyc(2);
		presetn <= 1'b1;
		t_regs;
		t_edge;
		t_lvl;
		final_report;
	end
	// Watchdog, far beyond the roughly 130 cycles needed
	initial begin
		#20000;
		failures++;
		final_report;
	end
endmodule // io_line_event_detector_tb_top
`default_nettype wire
